/* logic/ivp_pkg.sv */
package ivp_pkg;

    // program word address width, covers the whole 4K-word memory
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned NUM_IRQ    = 25;
    localparam int unsigned IDX_W      = 5;

    // reset targets
    localparam logic [ADDR_W-1:0] RESET_ADDR_APP  = 12'h000;
    // start of the boot flash section, fixed at 12'hc00
    localparam logic [ADDR_W-1:0] BOOT_RESET_ADDR = 12'hc00;

    // interrupt table base for each vector-select setting
    localparam logic [ADDR_W-1:0] TABLE_BASE_APP  = 12'h001;
    localparam logic [ADDR_W-1:0] TABLE_BASE_BOOT = BOOT_RESET_ADDR + 12'h001;

    // fuse level after reset and meaning of the programmed state
    localparam logic FUSE_RESET_VAL  = 1'b1;
    localparam logic FUSE_PROGRAMMED = 1'b0;

    // request bit positions, lowest number wins
    localparam int unsigned IRQ_EXT_ZERO       = 0;
    localparam int unsigned IRQ_EXT_ONE        = 1;
    localparam int unsigned IRQ_PIN_CHG_ZERO   = 2;
    localparam int unsigned IRQ_PIN_CHG_ONE    = 3;
    localparam int unsigned IRQ_PIN_CHG_TWO    = 4;
    localparam int unsigned IRQ_WATCHDOG       = 5;
    localparam int unsigned IRQ_TMR2_CMP_A     = 6;
    localparam int unsigned IRQ_TMR2_CMP_B     = 7;
    localparam int unsigned IRQ_TMR2_OVF       = 8;
    localparam int unsigned IRQ_TMR1_CAPT      = 9;
    localparam int unsigned IRQ_TMR1_CMP_A     = 10;
    localparam int unsigned IRQ_TMR1_CMP_B     = 11;
    localparam int unsigned IRQ_TMR1_OVF       = 12;
    localparam int unsigned IRQ_TMR0_CMP_A     = 13;
    localparam int unsigned IRQ_TMR0_CMP_B     = 14;
    localparam int unsigned IRQ_TMR0_OVF       = 15;
    localparam int unsigned IRQ_SPI_DONE       = 16;
    localparam int unsigned IRQ_UART_RX_DONE   = 17;
    localparam int unsigned IRQ_TX_BUF_EMPTY   = 18;
    localparam int unsigned IRQ_UART_TX_DONE   = 19;
    localparam int unsigned IRQ_CONV_DONE      = 20;
    localparam int unsigned IRQ_NV_DATA_READY  = 21;
    localparam int unsigned IRQ_ANALOG_CMP     = 22;
    localparam int unsigned IRQ_TWO_WIRE       = 23;
    localparam int unsigned IRQ_PROG_STORE_RDY = 24;

    // one-word table offsets, indexed by request bit
    localparam logic [ADDR_W-1:0] VEC_OFFSET [NUM_IRQ] = '{
        12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
        12'h007, 12'h008, 12'h009, 12'h00a, 12'h00b, 12'h00c, 12'h00d,
        12'h00e, 12'h00f, 12'h010, 12'h011, 12'h012, 12'h013, 12'h014,
        12'h015, 12'h016, 12'h017, 12'h018, 12'h019
    };

    typedef enum logic [1:0] {
        IVP_ST_CAPTURE = 2'b01,
        IVP_ST_RUN     = 2'b10
    } ivp_state_t;

endpackage

/* logic/ivp_prio_enc.sv */
`timescale 1ns/1ps

module ivp_prio_enc
    import ivp_pkg::*;
(
    // pending requests, bit 0 is the highest priority
    input  wire logic [NUM_IRQ-1:0] pend_i,
    // selected request
    output logic                    any_o,
    output logic [IDX_W-1:0]        idx_o
);

    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        // scan downward so the lowest set bit is left last
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (pend_i[i]) begin
                any_o = 1'b1;
                idx_o = IDX_W'(i);
            end
        end
    end

endmodule

/* logic/ivp_top.sv */
`timescale 1ns/1ps

module ivp_top
    import ivp_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               reset_n_i,
    // configuration
    input  wire logic               boot_reset_fuse_i,
    input  wire logic               vector_select_i,
    // interrupt sources
    input  wire logic [NUM_IRQ-1:0] irq_req_i,
    input  wire logic [NUM_IRQ-1:0] irq_en_i,
    // fetch addresses to the core
    output logic [ADDR_W-1:0]       reset_addr_o,
    output logic                    reset_addr_valid_o,
    output logic [ADDR_W-1:0]       vector_addr_o,
    output logic [IDX_W-1:0]        vector_num_o,
    output logic                    vector_valid_o
);

    logic [1:0]         rst_sync_reg;
    logic               rst_n;
    logic [2:0]         fuse_sync_reg;
    logic [2:0]         fuse_fill_reg;
    logic               fuse_reg;
    ivp_state_t         state_reg;
    logic [NUM_IRQ-1:0] pend;
    logic               pend_any;
    logic [IDX_W-1:0]   pend_idx;
    logic [ADDR_W-1:0]  table_base;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // fuse strap enters from outside the clock domain
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            fuse_sync_reg <= {3{FUSE_RESET_VAL}};
        end else begin
            fuse_sync_reg <= {fuse_sync_reg[1:0], boot_reset_fuse_i};
        end
    end

    // marks stages that hold a pin sample, so the reset fill is never captured
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            fuse_fill_reg <= 3'h0;
        end else begin
            fuse_fill_reg <= {fuse_fill_reg[1:0], 1'b1};
        end
    end

    // latch the fuse once the synchroniser agrees, then hold it
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= IVP_ST_CAPTURE;
            fuse_reg  <= FUSE_RESET_VAL;
        end else begin
            case (state_reg)
                IVP_ST_CAPTURE: begin
                    if (fuse_fill_reg[2] && (fuse_sync_reg[2] == fuse_sync_reg[1])) begin
                        fuse_reg  <= fuse_sync_reg[2];
                        state_reg <= IVP_ST_RUN;
                    end
                end
                IVP_ST_RUN: begin
                    state_reg <= IVP_ST_RUN;
                end
                default: begin
                    state_reg <= IVP_ST_CAPTURE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reset_addr_o       <= RESET_ADDR_APP;
            reset_addr_valid_o <= 1'b0;
        end else begin
            reset_addr_o       <= (fuse_reg == FUSE_PROGRAMMED) ? BOOT_RESET_ADDR
                                                                : RESET_ADDR_APP;
            reset_addr_valid_o <= (state_reg == IVP_ST_RUN);
        end
    end

    // only enabled requests compete
    genvar g;
    generate
        for (g = 0; g < NUM_IRQ; g++) begin : g_pend
            assign pend[g] = irq_req_i[g] & irq_en_i[g];
        end
    endgenerate

    ivp_prio_enc u_prio (
        .pend_i (pend),
        .any_o  (pend_any),
        .idx_o  (pend_idx)
    );

    assign table_base = vector_select_i ? TABLE_BASE_BOOT : TABLE_BASE_APP;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            vector_addr_o  <= TABLE_BASE_APP;
            vector_num_o   <= '0;
            vector_valid_o <= 1'b0;
        end else begin
            vector_addr_o  <= table_base + VEC_OFFSET[pend_idx] - TABLE_BASE_APP;
            vector_num_o   <= pend_idx;
            vector_valid_o <= pend_any;
        end
    end

    // checks

    property p_reset_app;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (fuse_reg != FUSE_PROGRAMMED) |=> (reset_addr_o == 12'h000);
    endproperty
    a_reset_app: assert property (p_reset_app)
        else $error("reset target not zero with fuse unprogrammed");

    property p_reset_boot;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (fuse_reg == FUSE_PROGRAMMED) |=> (reset_addr_o == BOOT_RESET_ADDR);
    endproperty
    a_reset_boot: assert property (p_reset_boot)
        else $error("reset target not boot address with fuse programmed");

    property p_ext_one;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[1:0] == 2'b10 && !vector_select_i)
            |=> (vector_addr_o == 12'h002) && vector_valid_o;
    endproperty
    a_ext_one: assert property (p_ext_one)
        else $error("external request one vector wrong");

    property p_watchdog;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[5:0] == 6'h20 && !vector_select_i) |=> (vector_addr_o == 12'h006);
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog vector wrong");

    property p_tmr2_ovf;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[8:0] == 9'h100 && !vector_select_i) |=> (vector_addr_o == 12'h009);
    endproperty
    a_tmr2_ovf: assert property (p_tmr2_ovf)
        else $error("timer 2 overflow vector wrong");

    property p_tmr1_capt;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[9:0] == 10'h200 && !vector_select_i) |=> (vector_addr_o == 12'h00a);
    endproperty
    a_tmr1_capt: assert property (p_tmr1_capt)
        else $error("timer 1 capture vector wrong");

    property p_tmr0_ovf;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[15:0] == 16'h8000 && !vector_select_i) |=> (vector_addr_o == 12'h010);
    endproperty
    a_tmr0_ovf: assert property (p_tmr0_ovf)
        else $error("timer 0 overflow vector wrong");

    property p_uart_rx;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[17:0] == 18'h20000 && !vector_select_i) |=> (vector_addr_o == 12'h012);
    endproperty
    a_uart_rx: assert property (p_uart_rx)
        else $error("receive complete vector wrong");

    property p_store_rdy;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend == 25'h1000000 && !vector_select_i) |=> (vector_addr_o == 12'h019);
    endproperty
    a_store_rdy: assert property (p_store_rdy)
        else $error("program store ready vector wrong");

    property p_relocated;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend_any && vector_select_i)
            |=> (vector_addr_o == BOOT_RESET_ADDR + VEC_OFFSET[$past(pend_idx)]);
    endproperty
    a_relocated: assert property (p_relocated)
        else $error("relocated vector not offset plus boot start");

    property p_base;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[0] && $changed(fuse_reg) == 1'b0)
            |=> (vector_addr_o == ($past(vector_select_i) ? 12'hc01 : 12'h001));
    endproperty
    a_base: assert property (p_base)
        else $error("table base wrong");

    property p_lowest;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (pend[3] && pend[7] && pend[2:0] == 3'h0) |=> (vector_num_o == 5'h03);
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("lowest pending request not selected");

    property p_no_wrap;
        @(posedge clk_sys_i) disable iff (!rst_n)
        vector_valid_o |-> (vector_addr_o >= 12'h001) && (vector_addr_o <= 12'hc19);
    endproperty
    a_no_wrap: assert property (p_no_wrap)
        else $error("vector address out of range");

endmodule

/* testbench/ivp_src_model.sv */
`timescale 1ns/1ps

module ivp_src_model
    import ivp_pkg::*;
(
    // clock
    input  wire logic               clk_sys_i,
    // commands from the bench
    input  wire logic [NUM_IRQ-1:0] req_cmd_i,
    input  wire logic [NUM_IRQ-1:0] en_cmd_i,
    input  wire logic               sel_cmd_i,
    // levels toward the controller
    output logic [NUM_IRQ-1:0]      irq_req_o,
    output logic [NUM_IRQ-1:0]      irq_en_o,
    output logic                    vector_select_o
);
    initial begin
        irq_req_o = '0;
        irq_en_o = '0;
        vector_select_o = 1'b0;
    end

    always @(negedge clk_sys_i) begin
        irq_req_o <= req_cmd_i;
        irq_en_o <= en_cmd_i;
        vector_select_o <= sel_cmd_i;
    end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) \
    begin \
        checks++; \
        if ((e) !== (s)) begin \
            bad_count++; \
            $display("[ERR] %s expected %0h seen %0h", nm, e, s); \
        end \
    end

module testbench
    import ivp_pkg::*;
();
    logic               clk_sys_i;
    logic               reset_n_i;
    logic               fuse;
    logic [NUM_IRQ-1:0] req_cmd;
    logic [NUM_IRQ-1:0] en_cmd;
    logic               sel_cmd;
    logic [NUM_IRQ-1:0] irq_req;
    logic [NUM_IRQ-1:0] irq_en;
    logic               vsel;
    logic [ADDR_W-1:0]  reset_addr;
    logic               reset_valid;
    logic [ADDR_W-1:0]  vec_addr;
    logic [IDX_W-1:0]   vec_num;
    logic               vec_valid;
    logic [31:0]        ra;
    logic [31:0]        rb;
    logic [31:0]        rc;
    logic [17:0]        exp_cur;
    logic [17:0]        exp_q [$];
    int                 bad_count = 0;
    int                 checks = 0;
    int                 seed = 85;

    ivp_src_model u_src (
        .clk_sys_i(clk_sys_i), .req_cmd_i(req_cmd), .en_cmd_i(en_cmd), .sel_cmd_i(sel_cmd),
        .irq_req_o(irq_req), .irq_en_o(irq_en), .vector_select_o(vsel)
    );

    ivp_top dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .boot_reset_fuse_i(fuse),
        .vector_select_i(vsel), .irq_req_i(irq_req), .irq_en_i(irq_en),
        .reset_addr_o(reset_addr), .reset_addr_valid_o(reset_valid),
        .vector_addr_o(vec_addr), .vector_num_o(vec_num), .vector_valid_o(vec_valid)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // packs valid, winning index and word address
    function automatic logic [17:0] expect_vec(input logic [NUM_IRQ-1:0] r,
                                               input logic [NUM_IRQ-1:0] e, input logic s);
        logic [NUM_IRQ-1:0] p;
        logic [IDX_W-1:0]   idx;
        logic [ADDR_W-1:0]  base;
        logic               v;
        p = r & e;
        idx = '0;
        v = 1'b0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (p[i]) begin
                idx = i[IDX_W-1:0];
                v = 1'b1;
            end
        end
        base = s ? (BOOT_RESET_ADDR + 12'h001) : 12'h001;
        return {v, idx, base + {7'h00, idx}};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic drive(input logic [NUM_IRQ-1:0] r, input logic [NUM_IRQ-1:0] e,
                         input logic s);
        @(posedge clk_sys_i);
        #2;
        req_cmd = r;
        en_cmd = e;
        sel_cmd = s;
        exp_q.push_back(expect_vec(r, e, s));
    endtask

    task automatic do_reset(input logic f, input logic s, input logic [ADDR_W-1:0] ea);
        int n;
        // mid-run: let queued compares finish before the outputs are forced back
        if (reset_n_i === 1'b1) begin
            repeat (2) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
        end
        reset_n_i = 1'b0;
        fuse = f;
        sel_cmd = s;
        repeat (12) @(negedge clk_sys_i);
        `CHK("reset_valid_low", 1'b0, reset_valid)
        reset_n_i = 1'b1;
        n = 0;
        while (reset_valid !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            $display("[ERR] reset_valid expected 1 seen %0h", reset_valid);
            tally_and_finish();
        end else begin
            `CHK("reset_addr", ea, reset_addr)
        end
    endtask

    // compares each noted expectation one cycle after it was applied
    always @(posedge clk_sys_i) begin
        #1;
        if (exp_q.size() > 0) begin
            exp_cur = exp_q.pop_front();
            `CHK("vec_valid", exp_cur[17], vec_valid)
            if (exp_cur[17]) begin
                `CHK("vec_addr", exp_cur[11:0], vec_addr)
                `CHK("vec_addr_sel", exp_cur[11:0], vec_addr)
                `CHK("vec_base", exp_cur[11:0], vec_addr)
                `CHK("vec_num", exp_cur[16:12], vec_num)
            end
        end
    end

    initial begin
        reset_n_i = 1'b0;
        fuse = FUSE_RESET_VAL;
        req_cmd = '0;
        en_cmd = '0;
        sel_cmd = 1'b0;
        do_reset(1'b1, 1'b0, 12'h000);
        // each source alone, both table placements
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                drive(25'h1 << i, 25'h1 << i, s[0]);
            end
        end
        // pending but disabled, then all pending, then only the last
        drive('1, '0, 1'b0);
        drive('1, '1, 1'b1);
        drive('1, 25'h1 << (NUM_IRQ - 1), 1'b1);
        for (int k = 0; k < 300; k++) begin
            ra = $random(seed);
            rb = $random(seed);
            rc = $random(seed);
            drive(ra[24:0] & rc[24:0], rb[24:0], rc[31]);
        end
        // boot reset target with table moved, fuse change afterwards ignored
        do_reset(FUSE_PROGRAMMED, 1'b1, BOOT_RESET_ADDR);
        drive(25'h1, 25'h1, 1'b0);
        drive(25'h3 << 23, '1, 1'b1);
        @(negedge clk_sys_i);
        fuse = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        `CHK("reset_addr_hold", BOOT_RESET_ADDR, reset_addr)
        do_reset(1'b1, 1'b1, 12'h000);
        drive(25'h1 << 5, 25'h1 << 5, 1'b1);
        repeat (3) @(posedge clk_sys_i);
        tally_and_finish();
    end
endmodule
